/* core/fplg_classify.sv */
// per-request permission decision
`timescale 1ns/1ps
`default_nettype none
`include "fplg_params.svh"
module fplg_classify
    import fplg_pkg::*;
(
    input wire fplg_src_t src,
    input wire fplg_op_t op,
    input wire logic [`FPLG_ADDR_W-1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] lock_byte,
    output fplg_verdict_t verdict
);
    localparam int PW = `FPLG_ADDR_W - `FPLG_PAGE_SHIFT;
    logic [PW-1:0] page;
    logic [PW-1:0] lock_page;
    logic [7:0] nlocked;
    logic any_locked;
    logic in_lock_page;
    logic in_rsvd;
    logic page_locked;
    logic is_lock_byte;
    logic refuse;
    logic fw_any_reset;
    always_comb begin
        page = addr[`FPLG_ADDR_W-1:`FPLG_PAGE_SHIFT];
        lock_page = PW'(`FPLG_LOCK_ADDR >> `FPLG_PAGE_SHIFT);
        nlocked = ~lock_byte;
        // lock page follows any zero bit
        any_locked = (lock_byte != `FPLG_LOCK_RESET);
        in_lock_page = (page == lock_page);
        in_rsvd = (addr >= `FPLG_RSVD_BASE);
        page_locked = ({{(8-PW){1'b0}}, page} < nlocked);
        is_lock_byte = (addr == `FPLG_LOCK_ADDR);
        refuse = 1'b0;
        fw_any_reset = 1'b0;
        if (op == FPLG_OP_DEV_ERASE) begin
            fw_any_reset = 1'b1;
        end else if (in_rsvd) begin
            fw_any_reset = 1'b1;
        end else if (in_lock_page && op == FPLG_OP_ERASE) begin
            // lock page erase; refuses debug if locked
            fw_any_reset = 1'b1;
            refuse = any_locked;
        end else if (is_lock_byte && op == FPLG_OP_WRITE && wdata != lock_byte) begin
            // lock byte bits are frozen; any write that changes them is refused
            fw_any_reset = 1'b1;
        end else if (in_lock_page) begin
            refuse = any_locked;
        end else begin
            refuse = page_locked;
        end
        if (src == FPLG_SRC_DEBUG) begin
            verdict = (refuse || (fw_any_reset && op != FPLG_OP_ERASE
                && op != FPLG_OP_DEV_ERASE) || (in_rsvd)) ? FPLG_OUT_IGNORE : FPLG_OUT_ALLOW;
        end else if (fw_any_reset) begin
            verdict = FPLG_OUT_RESET;
        end else if (refuse) begin
            verdict = (src == FPLG_SRC_FW_LOCKED) ? FPLG_OUT_ALLOW : FPLG_OUT_RESET;
        end else begin
            verdict = FPLG_OUT_ALLOW;
        end
    end
endmodule : fplg_classify
`default_nettype wire

/* core/fplg_guard.sv */
// flash page lock guard: routes and polices every flash request
// How it works
// - data-space reads go to expansion RAM
// - write needs write enable; erase both
// - inverted lock byte counts locked pages
// - lock page locked when any bit zero
// - unlocked pages open to every source
// - locked pages: debug refused, unlocked firmware resets
// - lock page access follows lock state
// - lock byte read follows same pattern
// - unlocked lock page erase: debug only
// - locked: only debug device erase clears
// - lock byte bit changes by write always forbidden
// - reserved area forbidden to everyone
// - firmware violation resets, sets error flag
// - debug violations dropped without reset
// - lock byte fixed except device erase
// - new lock byte effective after reset
// - interrupts held during flash operation
// - key pair arms one modification
// - erase write clears whole page
`timescale 1ns/1ps
`default_nettype none
`include "fplg_params.svh"
module fplg_guard
    import fplg_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic power_on_reset,
    input wire logic [7:0] lock_byte_stored,
    input wire logic program_store_write_enable,
    input wire logic page_erase_enable,
    input wire logic flash_key_wr,
    input wire logic [7:0] flash_key_data,
    input wire fplg_req_t cpu_req,
    input wire logic cpu_req_write,
    input wire logic debug_req_valid,
    input wire fplg_op_t debug_req_op,
    input wire logic [`FPLG_ADDR_W-1:0] debug_req_addr,
    input wire logic [7:0] debug_req_data,
    input wire logic flash_busy,
    input wire logic irq_pending,
    output fplg_flash_cmd_t flash_cmd,
    output logic xram_read,
    output logic [`FPLG_ADDR_W-1:0] xram_addr,
    output logic debug_dropped,
    output logic flash_error_reset,
    output logic flash_error_flag,
    output logic irq_hold,
    output logic [7:0] lock_byte_active
);
    typedef struct packed {
        fplg_flash_cmd_t cmd;
        logic xrd;
        logic [`FPLG_ADDR_W-1:0] xaddr;
        logic dropped;
        logic err_rst;
        logic hold;
        logic [7:0] lock;
        logic lock_loaded;
    } fplg_state_t;
    fplg_state_t q;
    fplg_state_t next_q;
    fplg_src_t fw_src;
    fplg_op_t fw_op;
    fplg_verdict_t fw_verdict;
    fplg_verdict_t dbg_verdict;
    logic fw_flash_mod;
    logic fw_flash_read;
    logic key_armed;
    logic key_dead;
    logic [7:0] lock_eff;
    // own register: it is reset by power-on only, not by rst
    logic err_flag;
    logic next_err_flag;
    localparam int PW = `FPLG_ADDR_W - `FPLG_PAGE_SHIFT;
    always_comb begin
        // lock register resets to all ones, so it is in force as is
        lock_eff = q.lock;
        fw_src = ({{(8-PW){1'b0}}, cpu_req.pc[`FPLG_ADDR_W-1:`FPLG_PAGE_SHIFT]} < ~lock_eff
            || (lock_eff != `FPLG_LOCK_RESET
            && cpu_req.pc[`FPLG_ADDR_W-1:`FPLG_PAGE_SHIFT]
            == PW'(`FPLG_LOCK_ADDR >> `FPLG_PAGE_SHIFT)))
            ? FPLG_SRC_FW_LOCKED : FPLG_SRC_FW_UNLOCKED;
        // write targets flash only with write enable
        fw_flash_mod = cpu_req.valid && cpu_req.fw && cpu_req_write && !cpu_req.code_space
            && program_store_write_enable;
        fw_flash_read = cpu_req.valid && cpu_req.fw && !cpu_req_write && cpu_req.code_space;
        // erase enable turns a write into page erase
        fw_op = !fw_flash_mod ? FPLG_OP_READ
            : (page_erase_enable ? FPLG_OP_ERASE : FPLG_OP_WRITE);
    end
    fplg_classify u_fw_cls (
        .src(fw_src),
        .op(fw_op),
        .addr(cpu_req.addr),
        .wdata(cpu_req.data),
        .lock_byte(lock_eff),
        .verdict(fw_verdict)
    );
    fplg_classify u_dbg_cls (
        .src(FPLG_SRC_DEBUG),
        .op(debug_req_op),
        .addr(debug_req_addr),
        .wdata(debug_req_data),
        .lock_byte(lock_eff),
        .verdict(dbg_verdict)
    );
    fplg_key_lock u_key (
        .clk(clk),
        .rst(rst),
        .key_wr(flash_key_wr),
        .key_data(flash_key_data),
        .fw_mod(fw_flash_mod),
        .armed(key_armed),
        .dead(key_dead)
    );
    always_comb begin
        next_q = q;
        next_q.cmd = '0;
        next_q.xrd = 1'b0;
        next_q.dropped = 1'b0;
        next_q.err_rst = 1'b0;
        // lock sampled once after reset release only
        if (!q.lock_loaded) begin
            next_q.lock = lock_byte_stored;
            next_q.lock_loaded = 1'b1;
        end
        // data-space reads always go to xram
        if (cpu_req.valid && cpu_req.fw && !cpu_req_write && !cpu_req.code_space) begin
            next_q.xrd = 1'b1;
            next_q.xaddr = cpu_req.addr;
        end
        // verdict decided before any command issues
        if (fw_flash_mod || fw_flash_read) begin
            if (fw_verdict == FPLG_OUT_RESET) begin
                next_q.err_rst = 1'b1;
            end else if (fw_flash_mod && !key_armed) begin
                next_q.cmd = '0;
            end else begin
                next_q.cmd = '{valid: 1'b1, op: fw_op, addr: cpu_req.addr, data: cpu_req.data};
            end
        end else if (debug_req_valid) begin
            if (dbg_verdict == FPLG_OUT_ALLOW) begin
                next_q.cmd = '{valid: 1'b1, op: debug_req_op, addr: debug_req_addr,
                    data: debug_req_data};
            end else begin
                next_q.dropped = 1'b1;
            end
        end
        // flag survives the reset it causes
        next_err_flag = err_flag;
        if (q.err_rst) begin
            next_err_flag = 1'b1;
        end else if (power_on_reset) begin
            next_err_flag = 1'b0;
        end
        // interrupts held while array is busy
        next_q.hold = flash_busy || next_q.cmd.valid;
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q.cmd <= '0;
            q.xrd <= 1'b0;
            q.xaddr <= '0;
            q.dropped <= 1'b0;
            q.err_rst <= 1'b0;
            q.hold <= 1'b0;
            q.lock <= `FPLG_LOCK_RESET;
            q.lock_loaded <= 1'b0;
        end else begin
            q.cmd <= next_q.cmd;
            q.xrd <= next_q.xrd;
            q.xaddr <= next_q.xaddr;
            q.dropped <= next_q.dropped;
            q.err_rst <= next_q.err_rst;
            q.hold <= next_q.hold;
            q.lock <= next_q.lock;
            q.lock_loaded <= next_q.lock_loaded;
        end
    end
    // error flag lives through system reset; only power-on clears it
    always_ff @(posedge clk or posedge power_on_reset) begin
        if (power_on_reset) begin
            err_flag <= 1'b0;
        end else begin
            err_flag <= next_err_flag;
        end
    end
    assign flash_cmd = q.cmd;
    assign xram_read = q.xrd;
    assign xram_addr = q.xaddr;
    assign debug_dropped = q.dropped;
    assign flash_error_reset = q.err_rst;
    assign flash_error_flag = err_flag;
    assign irq_hold = q.hold;
    assign lock_byte_active = q.lock;
    // a_dbg_no_reset
    a_dbg_no_reset: assert property (@(posedge clk) disable iff (rst)
        (debug_req_valid && !fw_flash_mod && !fw_flash_read) |=> !flash_error_reset)
        else $error("debug request caused reset");
    // a_fw_bad_resets
    a_fw_bad_resets: assert property (@(posedge clk) disable iff (rst)
        ((fw_flash_mod || fw_flash_read) && fw_verdict == FPLG_OUT_RESET)
        |=> flash_error_reset ##1 flash_error_flag)
        else $error("firmware violation without reset and flag");
    // a_no_cmd_on_reset
    a_no_cmd_on_reset: assert property (@(posedge clk) disable iff (rst)
        flash_error_reset |-> !flash_cmd.valid)
        else $error("flash command issued with reset");
    // a_data_read_xram
    a_data_read_xram: assert property (@(posedge clk) disable iff (rst)
        (cpu_req.valid && cpu_req.fw && !cpu_req_write && !cpu_req.code_space)
        |=> xram_read && !flash_cmd.valid)
        else $error("data-space read reached flash");
    // a_we_needed
    a_we_needed: assert property (@(posedge clk) disable iff (rst)
        (!program_store_write_enable && !debug_req_valid) |=>
        !(flash_cmd.valid && flash_cmd.op != FPLG_OP_READ))
        else $error("flash modified without write enable");
    // a_lock_stable
    a_lock_stable: assert property (@(posedge clk) disable iff (rst)
        $past(q.lock_loaded) |-> $stable(lock_byte_active))
        else $error("lock changed without reset");
    // a_dbg_refused
    a_dbg_refused: assert property (@(posedge clk) disable iff (rst)
        (debug_req_valid && !fw_flash_mod && !fw_flash_read
        && dbg_verdict != FPLG_OUT_ALLOW) |=> debug_dropped && !flash_cmd.valid)
        else $error("refused debug access went through");
    // a_unarmed_blocked
    a_unarmed_blocked: assert property (@(posedge clk) disable iff (rst)
        (fw_flash_mod && !key_armed) |=> !flash_cmd.valid)
        else $error("unarmed write reached flash");
endmodule : fplg_guard
`default_nettype wire

/* core/fplg_key_lock.sv */
// key sequence that arms one firmware flash modification
`timescale 1ns/1ps
`default_nettype none
`include "fplg_params.svh"
module fplg_key_lock
    import fplg_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic key_wr,
    input wire logic [7:0] key_data,
    input wire logic fw_mod,
    output logic armed,
    output logic dead
);
    typedef struct packed {
        fplg_key_state_t st;
        logic dead;
    } fplg_key_reg_t;
    fplg_key_reg_t q;
    fplg_key_reg_t next_q;
    always_comb begin
        next_q = q;
        if (key_wr && !q.dead) begin
            if (q.st == FPLG_KEY_IDLE && key_data == `FPLG_KEY_FIRST) begin
                next_q.st = FPLG_KEY_HALF;
            end else if (q.st == FPLG_KEY_HALF && key_data == `FPLG_KEY_SECOND) begin
                next_q.st = FPLG_KEY_OPEN;
            end else begin
                next_q.dead = 1'b1;
                next_q.st = FPLG_KEY_IDLE;
            end
        end
        // a modification consumes the key; unarmed attempt kills until reset
        if (fw_mod) begin
            if (q.st != FPLG_KEY_OPEN) begin
                next_q.dead = 1'b1;
            end
            next_q.st = FPLG_KEY_IDLE;
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q <= '{st: FPLG_KEY_IDLE, dead: 1'b0};
        end else begin
            q <= next_q;
        end
    end
    assign armed = (q.st == FPLG_KEY_OPEN) && !q.dead;
    assign dead = q.dead;
    // a_key_wrong_kills
    a_key_wrong_kills: assert property (@(posedge clk) disable iff (rst)
        (key_wr && q.st == FPLG_KEY_IDLE && key_data != `FPLG_KEY_FIRST) |=> dead)
        else $error("wrong first key did not lock flash");
    // a_key_pair_arms
    a_key_pair_arms: assert property (@(posedge clk) disable iff (rst)
        (key_wr && q.st == FPLG_KEY_HALF && key_data == `FPLG_KEY_SECOND && !dead && !fw_mod)
        |=> armed)
        else $error("correct key pair did not arm");
endmodule : fplg_key_lock
`default_nettype wire

/* core/fplg_params.svh */
// constants for the flash page lock guard
`ifndef FPLG_PARAMS_SVH
`define FPLG_PARAMS_SVH
`define FPLG_ADDR_W 15
`define FPLG_PAGE_SHIFT 9
`define FPLG_PAGE_BYTES 16'h0200
`define FPLG_PAGE0_BASE 15'h0000
`define FPLG_LOCK_ADDR 15'h7BFF
`define FPLG_RSVD_BASE 15'h7C00
`define FPLG_KEY_FIRST 8'hA5
`define FPLG_KEY_SECOND 8'hF1
`define FPLG_LOCK_RESET 8'hFF
`define FPLG_PSC_WE_BIT 0
`define FPLG_PSC_EE_BIT 1
`endif

/* core/fplg_pkg.sv */
// types for the flash page lock guard
`include "fplg_params.svh"
package fplg_pkg;
    typedef enum logic [2:0] {
        FPLG_SRC_DEBUG = 3'h1,
        FPLG_SRC_FW_UNLOCKED = 3'h2,
        FPLG_SRC_FW_LOCKED = 3'h4
    } fplg_src_t;
    typedef enum logic [1:0] {
        FPLG_OP_READ = 2'h0,
        FPLG_OP_WRITE = 2'h1,
        FPLG_OP_ERASE = 2'h2,
        FPLG_OP_DEV_ERASE = 2'h3
    } fplg_op_t;
    typedef enum logic [2:0] {
        FPLG_OUT_ALLOW = 3'h1,
        FPLG_OUT_IGNORE = 3'h2,
        FPLG_OUT_RESET = 3'h4
    } fplg_verdict_t;
    typedef struct packed {
        logic valid;
        logic [`FPLG_ADDR_W-1:0] addr;
        logic [7:0] data;
        logic code_space;
        logic fw;
        logic [`FPLG_ADDR_W-1:0] pc;
    } fplg_req_t;
    typedef struct packed {
        logic valid;
        fplg_op_t op;
        logic [`FPLG_ADDR_W-1:0] addr;
        logic [7:0] data;
    } fplg_flash_cmd_t;
    typedef enum logic [2:0] {
        FPLG_KEY_IDLE = 3'h1,
        FPLG_KEY_HALF = 3'h2,
        FPLG_KEY_OPEN = 3'h4
    } fplg_key_state_t;
endpackage : fplg_pkg

/* sim/fplg_flash_model.sv */
// flash array stand-in: holds the lock byte cell and goes busy after each command
`timescale 1ns/1ps
`default_nettype none
`include "fplg_params.svh"
module fplg_flash_model
    import fplg_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire fplg_flash_cmd_t flash_cmd,
    input wire logic load,
    input wire logic [7:0] load_value,
    output logic [7:0] lock_byte_stored,
    output logic flash_busy
);
    // one clock only; oscillator choice is firmware's concern
    localparam logic [14:0] LOCK_A = `FPLG_LOCK_ADDR;
    logic [1:0] busy_cnt;
    logic [7:0] lock_cell;
    assign flash_busy = busy_cnt != 2'h0;
    assign lock_byte_stored = lock_cell;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy_cnt <= 2'h0;
        end else if (flash_cmd.valid) begin
            busy_cnt <= 2'h3;
        end else if (flash_busy) begin
            busy_cnt <= busy_cnt - 2'h1;
        end
    end
    // only load, erases and writes touch the cell
    always_ff @(posedge clk) begin
        if (load) begin
            lock_cell <= load_value;
        end else if (flash_cmd.valid && (flash_cmd.op == FPLG_OP_DEV_ERASE
                || (flash_cmd.op == FPLG_OP_ERASE && flash_cmd.addr[14:9] == LOCK_A[14:9]))) begin
            lock_cell <= 8'hFF;
        end else if (flash_cmd.valid && flash_cmd.op == FPLG_OP_WRITE
                && flash_cmd.addr == LOCK_A) begin
            // programming only clears bits
            lock_cell <= lock_cell & flash_cmd.data;
        end
    end
endmodule : fplg_flash_model
`default_nettype wire

/* sim/fplg_guard_tb.sv */
// self-checking bench for the flash page lock guard
`timescale 1ns/1ps
`default_nettype none
`include "fplg_params.svh"
module fplg_guard_tb;
    import fplg_pkg::*;
    localparam logic [14:0] LA = `FPLG_LOCK_ADDR;
    logic clk = 1'b0, rst = 1'b1, por = 1'b1, we = 1'b0, ee = 1'b0, kwr = 1'b0;
    logic dv = 1'b0, load = 1'b1, cwr = 1'b0;
    logic [7:0] kd = 8'h00, dd = 8'h00, lk_set = 8'hFF, lk_exp = 8'hFF, lk_now = 8'hFF;
    logic [14:0] da = 15'h0000;
    fplg_op_t dop = FPLG_OP_READ;
    fplg_req_t creq = '0;
    fplg_flash_cmd_t cmd;
    logic busy, xr, drop, fer, flag, hold;
    logic [7:0] lk_st, lk_act;
    logic [14:0] xa;
    int fails = 0, check_count = 0;
    logic [31:0] seed = 32'h8;
    always #50 clk = ~clk;
    fplg_guard i_dut (.clk(clk), .rst(rst), .power_on_reset(por), .lock_byte_stored(lk_st),
        .program_store_write_enable(we), .page_erase_enable(ee), .flash_key_wr(kwr),
        .flash_key_data(kd), .cpu_req(creq), .cpu_req_write(cwr), .debug_req_valid(dv),
        .debug_req_op(dop), .debug_req_addr(da), .debug_req_data(dd), .flash_busy(busy),
        .irq_pending(1'b0), .flash_cmd(cmd), .xram_read(xr), .xram_addr(xa),
        .debug_dropped(drop), .flash_error_reset(fer), .flash_error_flag(flag),
        .irq_hold(hold), .lock_byte_active(lk_act));
    fplg_flash_model i_flash (.clk(clk), .rst(rst), .flash_cmd(cmd), .load(load),
        .load_value(lk_set), .lock_byte_stored(lk_st), .flash_busy(busy));
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    function automatic fplg_verdict_t verdict_of(input logic dbg, input fplg_op_t op,
            input logic [14:0] a, input logic [7:0] d, input logic [14:0] pc, input logic [7:0] lk);
        logic [7:0] n;
        logic any, t_lk, s_lk, bad;
        n = ~lk;
        any = lk != 8'hFF;
        t_lk = ({2'h0, a[14:9]} < n) || (a[14:9] == LA[14:9] && any);
        s_lk = ({2'h0, pc[14:9]} < n) || (pc[14:9] == LA[14:9] && any);
        bad = a >= `FPLG_RSVD_BASE;
        if (!bad && op == FPLG_OP_ERASE && a[14:9] == LA[14:9]) bad = !dbg || any;
        if (!bad && op == FPLG_OP_WRITE && a == LA && d != lk) bad = 1'b1;
        if (!bad && op != FPLG_OP_DEV_ERASE && t_lk) bad = dbg || !s_lk;
        return bad ? (dbg ? FPLG_OUT_IGNORE : FPLG_OUT_RESET) : FPLG_OUT_ALLOW;
    endfunction : verdict_of
    task automatic chk_bit(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_bit
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_val
    task automatic set_lock(input logic [7:0] v);
        @(posedge clk);
        load <= 1'b1;
        lk_set <= v;
        @(posedge clk);
        load <= 1'b0;
        lk_exp = v;
        @(negedge clk);
        chk_val(32'(lk_act), 32'(lk_now));
    endtask : set_lock
    task automatic dev_rst();
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        lk_now = lk_exp;
        @(negedge clk);
        chk_val(32'(lk_act), 32'(lk_now));
    endtask : dev_rst
    task automatic keys(input logic [7:0] k1, input logic [7:0] k2);
        @(posedge clk);
        kwr <= 1'b1;
        kd <= k1;
        @(posedge clk);
        kd <= k2;
        @(posedge clk);
        kwr <= 1'b0;
    endtask : keys
    task automatic req(input logic dbg, input fplg_op_t op, input logic [14:0] a,
            input logic [7:0] d, input logic [14:0] pc, input logic cs, input logic arm,
            input logic wen, input logic blk);
        fplg_verdict_t v;
        logic x, mute, ok;
        int n;
        v = verdict_of(dbg, op, a, d, pc, lk_now);
        x = !dbg && op == FPLG_OP_READ && !cs;
        // code-space writes never reach flash
        mute = x || (!dbg && op != FPLG_OP_READ && (!wen || blk || cs));
        ok = v == FPLG_OUT_ALLOW && !mute;
        // re-keying an armed lock kills it, so arm only for a real modification
        if (arm && !dbg && op != FPLG_OP_READ && wen && !cs)
            keys(`FPLG_KEY_FIRST, `FPLG_KEY_SECOND);
        @(posedge clk);
        if (dbg) begin
            dv <= 1'b1;
            dop <= op;
            da <= a;
            dd <= d;
        end else begin
            creq <= '{1'b1, a, d, cs, 1'b1, pc};
            cwr <= op != FPLG_OP_READ;
            we <= wen && op != FPLG_OP_READ;
            ee <= op == FPLG_OP_ERASE;
        end
        @(posedge clk);
        dv <= 1'b0;
        creq.valid <= 1'b0;
        cwr <= 1'b0;
        we <= 1'b0;
        ee <= 1'b0;
        @(negedge clk);
        chk_bit(xr, x);
        if (x) chk_val(32'(xa), 32'(a));
        chk_bit(cmd.valid, ok);
        if (ok) chk_val({15'h0, cmd.op, cmd.addr}, {15'h0, op, a});
        chk_bit(drop, v == FPLG_OUT_IGNORE && !mute);
        chk_bit(fer, v == FPLG_OUT_RESET && !mute);
        if (ok && (op == FPLG_OP_DEV_ERASE || (op == FPLG_OP_ERASE && a[14:9] == LA[14:9])))
            lk_exp = 8'hFF;
        if (ok && op != FPLG_OP_READ) begin
            repeat (2) @(negedge clk);
            chk_bit(hold, 1'b1);
        end
        if (v == FPLG_OUT_RESET && !mute) begin
            @(negedge clk);
            chk_bit(flag, 1'b1);
            dev_rst();
            chk_bit(flag, 1'b1);
            // power-on pulse clears the error flag
            @(posedge clk);
            por <= 1'b1;
            @(posedge clk);
            por <= 1'b0;
            @(negedge clk);
            chk_bit(flag, 1'b0);
        end
        for (n = 0; n < 20 && busy !== 1'b0; n++) @(negedge clk);
    endtask : req
    task automatic results();
        $display("checks=%0d mismatches=%0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : results
    initial begin
        #(100 * 30000);
        fails++;
        results();
    end
    initial begin
        logic [31:0] r, r2;
        logic [7:0] locks [4];
        fplg_op_t op;
        logic [14:0] a;
        locks = '{8'hFF, 8'hFE, 8'hF0, 8'hC1};
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        por <= 1'b0;
        load <= 1'b0;
        @(posedge clk);
        @(negedge clk);
        chk_val(32'(lk_act), 32'h0000_00FF);
        set_lock(8'hFD);
        dev_rst();
        req(1, FPLG_OP_READ, 15'h0200, 8'h00, 15'h0000, 0, 0, 1, 0);
        req(0, FPLG_OP_READ, 15'h0200, 8'h00, 15'h4000, 1, 0, 1, 0);
        req(0, FPLG_OP_READ, LA, 8'h00, 15'h0100, 1, 0, 1, 0);
        req(0, FPLG_OP_WRITE, LA, 8'h00, 15'h0100, 0, 1, 1, 0);
        req(1, FPLG_OP_WRITE, LA, 8'hFD, 15'h0000, 0, 0, 1, 0);
        req(1, FPLG_OP_ERASE, LA, 8'h00, 15'h0000, 0, 0, 1, 0);
        req(0, FPLG_OP_ERASE, 15'h7A00, 8'h00, 15'h0100, 0, 1, 1, 0);
        req(1, FPLG_OP_READ, 15'h7C10, 8'h00, 15'h0000, 0, 0, 1, 0);
        req(1, FPLG_OP_DEV_ERASE, 15'h0000, 8'h00, 15'h0000, 0, 0, 1, 0);
        dev_rst();
        req(0, FPLG_OP_ERASE, 15'h7A00, 8'h00, 15'h0400, 0, 1, 1, 0);
        req(1, FPLG_OP_ERASE, 15'h7A00, 8'h00, 15'h0000, 0, 0, 1, 0);
        req(0, FPLG_OP_WRITE, 15'h1234, 8'h5A, 15'h0400, 0, 1, 0, 0);
        req(0, FPLG_OP_ERASE, 15'h1234, 8'h5A, 15'h0400, 0, 1, 0, 0);
        req(0, FPLG_OP_READ, 15'h1234, 8'h00, 15'h0400, 0, 0, 1, 0);
        req(0, FPLG_OP_WRITE, 15'h1234, 8'h5A, 15'h0400, 0, 0, 1, 1);
        req(0, FPLG_OP_WRITE, 15'h1234, 8'h5A, 15'h0400, 0, 1, 1, 1);
        dev_rst();
        keys(`FPLG_KEY_SECOND, `FPLG_KEY_FIRST);
        req(0, FPLG_OP_WRITE, 15'h1234, 8'h5A, 15'h0400, 0, 0, 1, 1);
        dev_rst();
        $display("test directed done");
        foreach (locks[i]) begin
            set_lock(locks[i]);
            dev_rst();
            repeat (40) begin
                r = rnd();
                r2 = rnd();
                op = fplg_op_t'(r[1:0]);
                a = r[30:16];
                if (!r[2] && op == FPLG_OP_DEV_ERASE) op = FPLG_OP_ERASE;
                if (op == FPLG_OP_DEV_ERASE) a[14] = 1'b0;
                req(r[2], op, a, r[15:8], r2[14:0], r[3], 1, 1, 0);
            end
            $display("test random lock %h done", locks[i]);
        end
        results();
    end
endmodule : fplg_guard_tb
`default_nettype wire
